// >>> logic/decoder_host_port.sv
// host access port of the decoder: parallel byte bus (strobe or separate
// read/write strobes) or serial slave link, four byte registers to the DSP.
// assumes host pins are asynchronous to ref_clk and the serial clock is
// supplied by the host only while its chip select is low.
`timescale 1ns/100ps
`default_nettype none

// Contract
// - message pipe is two registers, inbound written by host, outbound by DSP.
// - handshake bit 6 holds the compressed input channel in reset.
// - handshake bit 5 holds the PCM input channel in reset.
// - handshake bit 4 reads the PCM buffer almost-full flag.
// - handshake bit 3 reads the compressed buffer almost-full flag.
// - bit 2 set by host pipe write, cleared by DSP read.
// - bit 1 set by DSP pipe write, cleared by host pipe read.
// - each host write to select 10b pushes a PCM byte.
// - each host write to select 11b pushes a compressed byte.
// - strobe style cycle active only while chip select and data strobe low.
// - strobe style read drives data only while direction high and both low.
// - strobe style write captured on first rise of select or strobe.
// - serial link is a slave; chip select low for whole transfer.
// - serial transfer starts with 7-bit address and direction; mismatch ignored.
// - stored device address resets to zero, loadable, check can be disabled.
// - serial input sampled MSB first on rising clock edges, whole bytes.
// - received byte handed over on the falling edge after bit eight.
// - attention held low while outbound data waits; host reads until released.
// - serial output changes on falling clock edges.
// - attention released after penultimate rising edge when nothing pending.
// - next outbound byte loads on falling edge of last bit when pending.
// - strobe and style pins at reset release choose the host mode.
// - separate strobe write captured on first rise of select or write strobe.
module decoder_host_port
    import decoder_host_port_pkg::*;
#(
    parameter int DATA_W = 8
)(
    input  wire logic       ref_clk,
    input  wire logic       rst_n,
    input  wire logic       chipSelectN,
    input  wire logic       readStrobeN,
    input  wire logic       writeStrobeN,
    input  wire logic       parallelStyle,
    input  wire logic [1:0] regSelect,
    input  wire logic [7:0] dataIn,
    output logic [7:0]      dataOut,
    output logic            dataOe,
    input  wire logic       serialShiftClock,
    input  wire logic       serialInLine,
    output logic            serialOutLine,
    output logic            attentionNOut,
    output logic            attentionNOe,
    output logic [7:0]      inboundData,
    output logic            inboundPending,
    input  wire logic       dspInboundTaken,
    input  wire logic       dspOutboundWrite,
    input  wire logic [7:0] dspOutboundData,
    output logic            outboundPending,
    input  wire logic       sampleBufferAlmostFull,
    input  wire logic       compressedBufferAlmostFull,
    output logic            samplePortHold,
    output logic            compressedPortHold,
    output logic            pcmPushValid,
    output logic            compressedPushValid,
    output logic [7:0]      pushData,
    input  wire logic       devAddrLoad,
    input  wire logic [6:0] devAddrValue,
    input  wire logic       addrCheckOff,
    output host_mode_t      hostMode
);

    // registers and pins are byte wide by construction
    if (DATA_W != 8) begin : g_bad_width
        $error("decoder_host_port supports DATA_W = 8 only");
    end

    core_t core_r;
    core_t core_nxt;
    rise_t rise_r;
    rise_t rise_nxt;
    fall_t fall_r;
    fall_t fall_nxt;
    pins_t pinNow;
    logic  frameRst;
    logic  wrNow;
    logic  rdNow;
    logic  rxEvent;
    logic  takeEvent;
    logic  wrEnd;
    logic  rdEnd;
    logic  loadNext;
    logic  accepted;

    assign pinNow = '{csN: chipSelectN, rdN: readStrobeN, wrN: writeStrobeN,
                      style: parallelStyle, sel: regSelect, data: dataIn};

    // rising-edge serial logic is cleared whenever the frame ends; the host clock may stop
    assign frameRst = !rst_n || chipSelectN || (core_r.mode != MODE_SPI);

    // cycle decode from the second synchroniser stage only
    always_comb
    begin
        wrNow = 1'b0;
        rdNow = 1'b0;
        if (core_r.mode == MODE_STROBE)
        begin
            // select and data strobe combined; read pin is the direction line
            wrNow = !core_r.pin2.csN && !core_r.pin2.wrN && core_r.pin2.rdN == 1'b0;
            rdNow = !core_r.pin2.csN && !core_r.pin2.wrN && core_r.pin2.rdN;
        end
        else if (core_r.mode == MODE_SEPARATE)
        begin
            wrNow = !core_r.pin2.csN && !core_r.pin2.wrN;
            rdNow = !core_r.pin2.csN && !core_r.pin2.rdN;
        end
    end

    assign wrEnd     = core_r.wrAct && !wrNow;
    assign rdEnd     = core_r.rdAct && !rdNow;
    assign rxEvent   = core_r.rxSync[2] != core_r.rxSync[1];
    assign takeEvent = core_r.takeSync[2] != core_r.takeSync[1];

    // core next state: straps, parallel cycles, pipe flags, serial hand-over
    always_comb
    begin
        core_nxt = core_r;
        core_nxt.pin1     = pinNow;
        core_nxt.pin2     = core_r.pin1;
        core_nxt.rxSync   = {core_r.rxSync[1:0], fall_r.rxTog};
        core_nxt.takeSync = {core_r.takeSync[1:0], fall_r.takeTog};
        core_nxt.pcmPush  = 1'b0;
        core_nxt.cmpPush  = 1'b0;
        core_nxt.wrAct    = wrNow;
        core_nxt.rdAct    = rdNow;
        // straps counted only once they have crossed the synchroniser
        if (core_r.strapCnt != STRAP_WAIT)
        begin
            core_nxt.strapCnt = core_r.strapCnt + 2'h1;
            if (core_r.strapCnt + 2'h1 == STRAP_WAIT)
            begin
                // only the second stage is read; the first may still be settling
                if (core_r.pin2.rdN && core_r.pin2.wrN)
                    core_nxt.mode = core_r.pin2.style ? MODE_STROBE : MODE_SEPARATE;
                else if (core_r.pin2.rdN && !core_r.pin2.wrN)
                    core_nxt.mode = MODE_SPI;
                else
                    core_nxt.mode = MODE_IDLE; // two-wire mode not built
            end
        end
        // keep the last data seen while the write strobe is low
        if (wrNow)
        begin
            core_nxt.wrData = core_r.pin2.data;
            core_nxt.wrSel  = core_r.pin2.sel;
        end
        // read data chosen while the strobe is low, handshake read is passive
        if (rdNow)
        begin
            core_nxt.rdSel = core_r.pin2.sel;
            if (core_r.pin2.sel == SEL_MSG)
                core_nxt.dout = core_r.msgOut;
            else if (core_r.pin2.sel == SEL_HS)
                core_nxt.dout = {1'b0, 2'b00, sampleBufferAlmostFull,
                                 compressedBufferAlmostFull,
                                 core_r.inPend, core_r.outPend, 1'b0};
            else
                core_nxt.dout = 8'h00; // write-only ports
        end
        // clears first so that a set in the same cycle wins
        if (dspInboundTaken)
            core_nxt.inPend = 1'b0;
        if ((rdEnd && core_r.rdSel == SEL_MSG) || takeEvent)
            core_nxt.outPend = 1'b0;
        if (wrEnd)
        begin
            if (core_r.wrSel == SEL_MSG)
            begin
                core_nxt.msgIn  = core_r.wrData;
                core_nxt.inPend = 1'b1;
            end
            else if (core_r.wrSel == SEL_HS)
            begin
                // reserved bits 7 and 0 are ignored
                core_nxt.cmpHold = core_r.wrData[HS_CMP_HOLD];
                core_nxt.pcmHold = core_r.wrData[HS_PCM_HOLD];
            end
            else if (core_r.wrSel == SEL_PCM)
            begin
                core_nxt.pcmPush  = 1'b1;
                core_nxt.pushData = core_r.wrData;
            end
            else
            begin
                core_nxt.cmpPush  = 1'b1;
                core_nxt.pushData = core_r.wrData;
            end
        end
        // serial bytes always land in the inbound pipe
        if (rxEvent)
        begin
            core_nxt.msgIn  = fall_r.rxByte;
            core_nxt.inPend = 1'b1;
        end
        if (dspOutboundWrite)
        begin
            core_nxt.msgOut  = dspOutboundData;
            core_nxt.outPend = 1'b1;
        end
        if (devAddrLoad)
            core_nxt.devAddr = devAddrValue;
    end

    // core registers
    always_ff @(posedge ref_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            core_r          <= '0;
            core_r.pin1     <= '1;
            core_r.pin2     <= '1;
            core_r.mode     <= MODE_IDLE;
            core_r.devAddr  <= DEV_ADDR_RST;
            core_r.cmpHold  <= HOLD_RST;
            core_r.pcmHold  <= HOLD_RST;
        end
        else
        begin
            core_r <= core_nxt;
        end
    end

    assign accepted = rise_r.accept;
    // a byte completes on a rising edge; the falling edge after it hands over
    assign loadNext = rise_r.byteReady && rise_r.isRead && accepted && rise_r.pend2;

    // rising-edge serial state: input shifter, header decode, attention timing
    always_comb
    begin
        rise_nxt = rise_r;
        rise_nxt.pend1     = core_r.outPend;
        rise_nxt.pend2     = rise_r.pend1;
        rise_nxt.cfg1      = {addrCheckOff, core_r.devAddr};
        rise_nxt.cfg2      = rise_r.cfg1;
        rise_nxt.shiftIn   = {rise_r.shiftIn[6:0], serialInLine};
        rise_nxt.bitCnt    = rise_r.bitCnt + 3'h1;
        rise_nxt.byteReady = rise_r.bitCnt == BIT_LAST;
        rise_nxt.headerByte = 1'b0;
        if (rise_r.bitCnt == BIT_LAST && !rise_r.headerDone)
        begin
            rise_nxt.headerDone = 1'b1;
            rise_nxt.headerByte = 1'b1;
            rise_nxt.isRead     = serialInLine;
            rise_nxt.accept     = rise_r.cfg2[7] ||
                                  rise_r.shiftIn[6:0] == rise_r.cfg2[6:0];
            rise_nxt.attnHold   = serialInLine && rise_r.pend2;
        end
        else if (rise_r.headerDone && rise_r.isRead && rise_r.accept)
        begin
            if (rise_r.bitCnt == BIT_PENULT)
            begin
                rise_nxt.attnHold  = rise_r.pend2;
                rise_nxt.attnBlock = !rise_r.pend2;
            end
            else if (rise_r.bitCnt == BIT_LAST)
            begin
                rise_nxt.attnBlock = 1'b0;
                rise_nxt.attnHold  = rise_r.pend2;
            end
        end
    end

    // rising-edge registers, cleared with the frame
    always_ff @(posedge serialShiftClock or posedge frameRst)
    begin
        if (frameRst)
            rise_r <= '0;
        else
            rise_r <= rise_nxt;
    end

    // falling-edge serial state: byte hand-over and output shifter
    always_comb
    begin
        fall_nxt = fall_r;
        fall_nxt.txShift = {fall_r.txShift[6:0], 1'b0};
        if (rise_r.byteReady && !rise_r.headerByte && !rise_r.isRead && accepted)
        begin
            fall_nxt.rxByte = rise_r.shiftIn;
            fall_nxt.rxTog  = !fall_r.rxTog;
        end
        if (loadNext)
        begin
            // outbound byte is stable while its pending flag is set
            fall_nxt.txShift = core_r.msgOut;
            fall_nxt.takeTog = !fall_r.takeTog;
        end
    end

    // toggles survive the frame so the core sees every event
    always_ff @(negedge serialShiftClock or negedge rst_n)
    begin
        if (!rst_n)
            fall_r <= '0;
        else
            fall_r <= fall_nxt;
    end

    // pins and user-side outputs
    assign dataOut         = core_r.dout;
    assign dataOe          = rdNow;
    assign serialOutLine   = fall_r.txShift[7];
    // open drain: pulled low while data waits, released per byte timing
    assign attentionNOut   = 1'b0;
    assign attentionNOe    = core_r.mode == MODE_SPI &&
                             ((core_r.outPend && !rise_r.attnBlock) || rise_r.attnHold);
    assign inboundData     = core_r.msgIn;
    assign inboundPending  = core_r.inPend;
    assign outboundPending = core_r.outPend;
    assign samplePortHold     = core_r.pcmHold;
    assign compressedPortHold = core_r.cmpHold;
    assign pcmPushValid        = core_r.pcmPush;
    assign compressedPushValid = core_r.cmpPush;
    assign pushData        = core_r.pushData;
    assign hostMode        = core_r.mode;

    // checks on the core clock
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);

    pcm_push_a: assert property (wrEnd && core_r.wrSel == SEL_PCM |=>
        pcmPushValid && pushData == $past(core_r.wrData) && !compressedPushValid)
        else $error("PCM write did not push one byte");
    cmp_push_a: assert property (wrEnd && core_r.wrSel == SEL_CMP |=>
        compressedPushValid && !pcmPushValid)
        else $error("compressed write did not push one byte");
    in_pend_set_a: assert property (wrEnd && core_r.wrSel == SEL_MSG |=>
        inboundPending && inboundData == $past(core_r.wrData))
        else $error("host pipe write did not set inbound pending");
    in_pend_clr_a: assert property (dspInboundTaken && !wrEnd && !rxEvent |=>
        !inboundPending)
        else $error("DSP read did not clear inbound pending");
    out_pend_a: assert property (dspOutboundWrite |=> outboundPending
        && $past(dspOutboundData) == core_r.msgOut)
        else $error("DSP pipe write did not set outbound pending");
    out_pend_clr_a: assert property (rdEnd && core_r.rdSel == SEL_MSG
        && !dspOutboundWrite |=> !outboundPending)
        else $error("host pipe read did not clear outbound pending");
    hs_passive_a: assert property (rdEnd && core_r.rdSel == SEL_HS && !takeEvent
        && !dspInboundTaken && !dspOutboundWrite && !rxEvent |=>
        $stable(inboundPending) && $stable(outboundPending))
        else $error("handshake read changed a flag");
    hold_bits_a: assert property (wrEnd && core_r.wrSel == SEL_HS |=>
        samplePortHold == $past(core_r.wrData[HS_PCM_HOLD]) &&
        compressedPortHold == $past(core_r.wrData[HS_CMP_HOLD]))
        else $error("channel hold bits not written");
    oe_gate_a: assert property (dataOe |-> !core_r.pin2.csN &&
        (core_r.mode != MODE_STROBE || (!core_r.pin2.wrN && core_r.pin2.rdN)))
        else $error("data bus driven outside a read cycle");
    strobe_act_a: assert property (core_r.mode == MODE_STROBE &&
        (core_r.pin2.csN || core_r.pin2.wrN) |-> !wrNow && !rdNow)
        else $error("strobe-style cycle active with select or strobe high");
    dev_addr_a: assert property (devAddrLoad |=> core_r.devAddr == $past(devAddrValue))
        else $error("device address not loaded");
    mode_fixed_a: assert property (core_r.strapCnt == STRAP_WAIT |=> $stable(hostMode))
        else $error("host mode changed after strap capture");

    // serial link check on its own clock
    attn_release_a: assert property (@(posedge serialShiftClock) disable iff (frameRst)
        rise_r.attnBlock |-> !rise_r.attnHold && !attentionNOe)
        else $error("attention held while release window open");

    pcm_write_c: cover property (wrEnd && core_r.wrSel == SEL_PCM);
    pipe_round_c: cover property (inboundPending && outboundPending);
    serial_rx_c: cover property (rxEvent);
    serial_take_c: cover property (takeEvent);

endmodule
`default_nettype wire

// >>> logic/decoder_host_port_pkg.sv
// package for the decoder host access port: register selects, handshake
// bit layout, mode codes and the state structs of the three clock processes.
// assumes an 8-bit host data path and a 7-bit serial device address.
`default_nettype none
package decoder_host_port_pkg;

    // register select codes on the two select pins
    localparam logic [1:0] SEL_MSG = 2'h0;
    localparam logic [1:0] SEL_HS  = 2'h1;
    localparam logic [1:0] SEL_PCM = 2'h2;
    localparam logic [1:0] SEL_CMP = 2'h3;

    // handshake register bit positions
    localparam int HS_CMP_HOLD = 6;
    localparam int HS_PCM_HOLD = 5;
    localparam int HS_PCM_FULL = 4;
    localparam int HS_CMP_FULL = 3;
    localparam int HS_IN_PEND  = 2;
    localparam int HS_OUT_PEND = 1;

    // reset values
    localparam logic [6:0] DEV_ADDR_RST = 7'h00;
    localparam logic       HOLD_RST     = 1'h0;

    // serial bit counts within a byte (0 = first bit)
    localparam logic [2:0] BIT_PENULT = 3'h6;
    localparam logic [2:0] BIT_LAST   = 3'h7;

    // edge after reset release at which the synchronised strap levels are decoded
    localparam logic [1:0] STRAP_WAIT = 2'h3;

    typedef enum logic [1:0] {
        MODE_STROBE   = 2'b00,
        MODE_SEPARATE = 2'b01,
        MODE_SPI      = 2'b10,
        MODE_IDLE     = 2'b11
    } host_mode_t;

    typedef struct packed {
        logic       csN;
        logic       rdN;
        logic       wrN;
        logic       style;
        logic [1:0] sel;
        logic [7:0] data;
    } pins_t;

    typedef struct packed {
        pins_t      pin1;
        pins_t      pin2;
        host_mode_t mode;
        logic [1:0] strapCnt;
        logic       wrAct;
        logic       rdAct;
        logic [1:0] wrSel;
        logic [7:0] wrData;
        logic [1:0] rdSel;
        logic [7:0] dout;
        logic [7:0] msgIn;
        logic [7:0] msgOut;
        logic       inPend;
        logic       outPend;
        logic       cmpHold;
        logic       pcmHold;
        logic [6:0] devAddr;
        logic [2:0] rxSync;
        logic [2:0] takeSync;
        logic       pcmPush;
        logic       cmpPush;
        logic [7:0] pushData;
    } core_t;

    typedef struct packed {
        logic       pend1;
        logic       pend2;
        logic [7:0] cfg1;
        logic [7:0] cfg2;
        logic [2:0] bitCnt;
        logic [7:0] shiftIn;
        logic       headerDone;
        logic       isRead;
        logic       accept;
        logic       byteReady;
        logic       headerByte;
        logic       attnHold;
        logic       attnBlock;
    } rise_t;

    typedef struct packed {
        logic [7:0] txShift;
        logic       takeTog;
        logic       rxTog;
        logic [7:0] rxByte;
    } fall_t;

endpackage
`default_nettype wire

// >>> verif/decoder_host_port_tb.sv
// bench for the decoder host port: both parallel styles, then the serial link.
// assumes host_model drives every host pin; pull-up on the attention line.
`timescale 1ns/100ps
`default_nettype none
module decoder_host_port_tb
    import decoder_host_port_pkg::*;
;
    logic       ref_clk = 1'b0, rst_n = 1'b0, chipSelectN, readStrobeN, writeStrobeN;
    logic       parallelStyle, serialShiftClock, serialInLine, serialOutLine, attentionNOut;
    logic       attentionNOe, dataOe, inboundPending, outboundPending, samplePortHold;
    logic       compressedPortHold, pcmPushValid, compressedPushValid, devAddrLoad = 1'b0;
    logic       dspInboundTaken = 1'b0, dspOutboundWrite = 1'b0, addrCheckOff = 1'b0;
    logic       sampleBufferAlmostFull = 1'b0, compressedBufferAlmostFull = 1'b0;
    logic [1:0] regSelect;
    logic [6:0] devAddrValue = 7'h00;
    logic [7:0] hostData, dataOut, inboundData, pushData, dspOutboundData = 8'h00, rv, r2;
    logic [7:0] pcmQ[$], cmpQ[$], prevIn;
    host_mode_t hostMode;
    int         bad_count = 0, n_compared = 0, cycles = 0, expIn;
    wire  [7:0] busWire = dataOe ? dataOut : hostData;
    wire        attnLine = attentionNOe ? attentionNOut : 1'b1;
    decoder_host_port u_decoder_host_port (.ref_clk, .rst_n, .chipSelectN, .readStrobeN,
        .writeStrobeN, .parallelStyle, .regSelect, .dataIn(busWire), .dataOut, .dataOe,
        .serialShiftClock, .serialInLine, .serialOutLine, .attentionNOut, .attentionNOe,
        .inboundData, .inboundPending, .dspInboundTaken, .dspOutboundWrite, .dspOutboundData,
        .outboundPending, .sampleBufferAlmostFull, .compressedBufferAlmostFull,
        .samplePortHold, .compressedPortHold, .pcmPushValid, .compressedPushValid, .pushData,
        .devAddrLoad, .devAddrValue, .addrCheckOff, .hostMode);
    host_model u_host_model (.ref_clk, .busWire, .serialOutLine, .chipSelectN, .readStrobeN,
        .writeStrobeN, .parallelStyle, .regSelect, .hostData, .serialShiftClock, .serialInLine);
    always #4 ref_clk = ~ref_clk;
    task automatic chkByte(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            bad_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // pushes checked off the edge against the model queues; also the hang limit
    always @(negedge ref_clk)
    begin
        if (pcmPushValid === 1'b1)
            chkByte(pushData, pcmQ.size() > 0 ? pcmQ.pop_front() : 8'hXX);
        if (compressedPushValid === 1'b1)
            chkByte(pushData, cmpQ.size() > 0 ? cmpQ.pop_front() : 8'hXX);
        bad_count += (++cycles == 20000);
        if (cycles == 20000) print_verdict();
    end
    // one-cycle pulse from the DSP side: outbound write or inbound taken
    task automatic dspPulse(input logic wr, input logic [7:0] d);
        @(posedge ref_clk);
        {dspOutboundWrite, dspInboundTaken, dspOutboundData} <= {wr, !wr, d};
        @(posedge ref_clk);
        {dspOutboundWrite, dspInboundTaken} <= 2'h0;
        repeat (3) @(posedge ref_clk);
    endtask
    task automatic rstSeq(input logic rN, input logic wN, input logic st);
        u_host_model.strap(rN, wN, st);
        rst_n <= 1'b0;
        repeat (10) @(posedge ref_clk);
        rst_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        u_host_model.strap(1'b1, 1'b1, st);
        expIn = 0;
    endtask
    // reads of the handshake register: flags only, never altered by the read
    task automatic chkHs();
        u_host_model.busCycle(1'b1, SEL_HS, 8'h00, r2);
        chkByte(r2, {3'h0, sampleBufferAlmostFull, compressedBufferAlmostFull,
                     expIn[0], expIn[1], 1'b0});
    endtask
    initial
    begin
        void'($urandom(24456));
        for (int m = 0; m < 2; m++)
        begin
            u_host_model.sepMode = m[0];
            rstSeq(1'b1, 1'b1, !m[0]);
            chkByte({6'h00, hostMode}, {6'h00, m ? MODE_SEPARATE : MODE_STROBE});
            {sampleBufferAlmostFull, compressedBufferAlmostFull} <= 2'($urandom);
            chkHs();
            rv = 8'($urandom) & 8'h7E | 8'h60;
            u_host_model.busCycle(1'b0, SEL_HS, rv, r2);
            chkByte({6'h00, compressedPortHold, samplePortHold}, 8'h03);
            chkHs();
            u_host_model.busCycle(1'b0, SEL_HS, 8'h00, r2);
            chkByte({6'h00, compressedPortHold, samplePortHold}, 8'h00);
            for (int k = 0; k < 4; k++)
            begin
                rv = 8'($urandom);
                if (k[0]) cmpQ.push_back(rv);
                else pcmQ.push_back(rv);
                u_host_model.busCycle(1'b0, k[0] ? SEL_CMP : SEL_PCM, rv, r2);
            end
            u_host_model.busCycle(1'b0, SEL_MSG, rv, r2);
            expIn = 1;
            chkByte(inboundData, rv);
            chkHs();
            dspPulse(1'b0, 8'h00);
            chkByte({7'h00, inboundPending}, 8'h00);
            expIn = 0;
            dspPulse(1'b1, ~rv);
            chkByte({7'h00, outboundPending}, 8'h01);
            expIn = 2;
            chkHs();
            u_host_model.busCycle(1'b1, SEL_MSG, 8'h00, r2);
            chkByte(r2, ~rv);
            chkByte({6'h00, outboundPending, dataOe}, 8'h00);
            u_host_model.busCycle(1'b1, SEL_PCM, 8'h00, r2);
            chkByte(r2, 8'h00);
            $display("parallel style %0d done", m);
        end
        // two-wire strap is not served: mode stays idle and the bus is ignored
        rstSeq(1'b0, 1'b1, 1'b1);
        chkByte({6'h00, hostMode}, {6'h00, MODE_IDLE});
        u_host_model.busCycle(1'b0, SEL_PCM, 8'h5A, r2);
        rstSeq(1'b1, 1'b0, 1'b1);
        chkByte({6'h00, hostMode}, {6'h00, MODE_SPI});
        for (int a = 0; a < 4; a++)
        begin
            devAddrValue <= 7'h05;
            devAddrLoad <= (a == 2);
            addrCheckOff <= (a == 3);
            @(posedge ref_clk);
            devAddrLoad <= 1'b0;
            rv = 8'($urandom);
            u_host_model.spiBegin();
            u_host_model.spiByte({(a == 1 || a == 2) ? 7'h05 : 7'h00, 1'b0}, r2);
            u_host_model.spiByte(~rv, r2);
            u_host_model.spiByte(rv, r2);
            u_host_model.spiEnd();
            chkByte({7'h00, inboundPending}, {7'h00, a != 1});
            chkByte(inboundData, a != 1 ? rv : prevIn);
            if (a != 1) prevIn = rv;
            dspPulse(1'b0, 8'h00);
        end
        dspPulse(1'b1, rv);
        chkByte({7'h00, attnLine}, 8'h00);
        u_host_model.spiBegin();
        u_host_model.spiByte({7'h05, 1'b1}, r2);
        fork
            u_host_model.spiByte(8'h00, r2);
            begin
                repeat (40) @(posedge ref_clk);
                dspPulse(1'b1, ~rv);
            end
        join
        chkByte(r2, rv);
        u_host_model.spiByte(8'h00, r2);
        chkByte(r2, ~rv);
        u_host_model.spiEnd();
        chkByte({6'h00, attnLine, outboundPending}, 8'h02);
        chkByte(8'(pcmQ.size() + cmpQ.size()), 8'h00);
        $display("serial link done");
        print_verdict();
    end
endmodule
`default_nettype wire

// >>> verif/host_model.sv
// host processor model: byte-wide bus cycles, serial slave frames, straps.
// assumes the bench resolves the shared data bus into busWire.
`timescale 1ns/100ps
`default_nettype none
module host_model
    import decoder_host_port_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic [7:0] busWire,
    input  wire logic       serialOutLine,
    output logic            chipSelectN,
    output logic            readStrobeN,
    output logic            writeStrobeN,
    output logic            parallelStyle,
    output logic [1:0]      regSelect,
    output logic [7:0]      hostData,
    output logic            serialShiftClock,
    output logic            serialInLine
);
    logic sepMode = 1'b0;
    // idle pins; serial clock stands low outside frames
    initial {chipSelectN, serialShiftClock, serialInLine, regSelect, hostData} = 13'h1000;
    // strap levels, sampled by the port at reset release
    task automatic strap(input logic r, input logic w, input logic p);
        readStrobeN <= r;
        writeStrobeN <= w;
        parallelStyle <= p;
    endtask
    // one byte cycle; strobes low six cycles so the synchroniser sees it
    task automatic busCycle(input logic rd, input logic [1:0] s, input logic [7:0] wd,
                            output logic [7:0] rdat);
        @(posedge ref_clk);
        regSelect <= s;
        hostData <= rd ? ~hostData : wd; // a reading host leaves no stale byte
        readStrobeN <= sepMode | rd;
        @(posedge ref_clk);
        chipSelectN <= 1'b0;
        readStrobeN <= sepMode ? !rd : rd;
        writeStrobeN <= sepMode & rd;
        repeat (6) @(posedge ref_clk);
        rdat = busWire;
        {chipSelectN, readStrobeN, writeStrobeN} <= 3'h7;
        hostData <= ~hostData; // released bus shows the inverse
        repeat (6) @(posedge ref_clk);
    endtask
    // frame start; phase offset keeps link edges off the core edge
    task automatic spiBegin();
        @(posedge ref_clk);
        chipSelectN <= 1'b0;
        #83;
    endtask
    // one byte, msb first, data changed while the link clock is low
    task automatic spiByte(input logic [7:0] w, output logic [7:0] r);
        for (int i = 7; i >= 0; i--)
        begin
            serialInLine <= w[i];
            #80 serialShiftClock <= 1'b1;
            r[i] = serialOutLine;
            #80 serialShiftClock <= 1'b0;
        end
    endtask
    // frame end after the final falling edge
    task automatic spiEnd();
        #80 chipSelectN <= 1'b1;
        serialInLine <= ~serialInLine;
        repeat (12) @(posedge ref_clk);
    endtask
endmodule
`default_nettype wire
